// File: rtl/pcs_consts.svh
// offsets, field positions and reset values of the chip-select port
// assumes byte addressing on the register bus, one 32-bit word per register
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH

`define PCS_PINS          4
`define PCS_OFF_PORT      8'hd8
`define PCS_OFF_BASE_HI0  8'h80
`define PCS_OFF_BASE_LO0  8'h84
`define PCS_BASE_STRIDE   8'h08
`define PCS_OFF_CTRL_A    8'ha0
`define PCS_OFF_CTRL_B    8'ha4
`define PCS_OFF_EXT_CTRL  8'ha8
`define PCS_PORT_RST      4'hf
`define PCS_REG_RST       8'h00
`define PCS_FLD_W         4
`define PCS_PINS_PER_CTRL 2
`define PCS_MODE_LSB      2
`define PCS_SIZE_LSB      0
`define PCS_INV_LSB       4
`define PCS_HI_ZERO       4'h0

`endif

// File: rtl/pcs_pkg.sv
// types shared by the chip-select port and its per-pin decoder
// assumes nothing beyond a single clock domain
package pcs_pkg;

	typedef enum logic [1:0] {
		PCS_GPIO = 2'h0,
		PCS_RD   = 2'h1,
		PCS_WR   = 2'h2,
		PCS_RW   = 2'h3
	} pcs_mode_t;

	typedef enum logic [1:0] {
		PCS_ST_IDLE = 2'h1,
		PCS_ST_ACK  = 2'h2
	} pcs_bus_st_t;

	// external data move as the core issues it; rd and wr are active high here
	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
		logic        wr;
	} pcs_xbus_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} pcs_wb_req_t;

	typedef struct packed {
		logic out;
		logic oe;
	} pcs_chan_st_t;

	typedef struct packed {
		pcs_bus_st_t     st;
		logic [31:0]     rdat;
		logic [3:0][7:0] base_hi;
		logic [3:0][7:0] base_lo;
		logic [7:0]      ctrl_a;
		logic [7:0]      ctrl_b;
		logic [7:0]      ext_ctrl;
		logic [3:0]      latch;
		logic [3:0]      s1;
		logic [3:0]      s2;
		logic [3:0]      s3;
		logic [3:0]      pin;
		logic            irq2_n;
		logic            irq3_n;
	} pcs_top_st_t;

endpackage

// File: rtl/pcs_chan.sv
// one pin of the chip-select port: address compare and pin drive
// assumes the external move signals come from logic on the same clock
module pcs_chan (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire pcs_pkg::pcs_xbus_t xbus_i,
	input  wire logic [15:0]       base_i,
	input  wire pcs_pkg::pcs_mode_t mode_i,
	input  wire logic [1:0]        size_i,
	input  wire logic              inv_i,
	input  wire logic              latch_i,
	output logic                   out_o,
	output logic                   oe_o
);
	import pcs_pkg::*;

	pcs_chan_st_t st_q;
	pcs_chan_st_t st_d;
	logic [15:0]  ignore;
	logic         match;
	logic         hit;

	always_comb begin
		// size picks how many low address bits the compare skips
		ignore = 16'((16'h0001 << size_i) - 16'h0001);
		match  = ((xbus_i.addr ^ base_i) & ~ignore) == 16'h0000;
		case (mode_i)
			PCS_RD:  hit = match & xbus_i.rd;
			PCS_WR:  hit = match & xbus_i.wr;
			PCS_RW:  hit = match & (xbus_i.rd | xbus_i.wr);
			default: hit = 1'b0;
		endcase
		st_d = st_q;
		if (mode_i == PCS_GPIO) begin
			// quasi-bidirectional: pull low for a 0, let the pull-up hold a 1
			st_d.out = 1'b0;
			st_d.oe  = ~latch_i;
		end else begin
			// idle level when no matching move; invert flips to active high
			st_d.out = inv_i ? hit : ~hit;
			st_d.oe  = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign out_o = st_q.out;
	assign oe_o  = st_q.oe;

	a_strobe_active: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode_i == PCS_WR && xbus_i.wr && xbus_i.addr == base_i)
		|=> (oe_o && out_o == $past(inv_i)))
		else $error("write strobe not active on matching move");

	a_strobe_rest: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode_i != PCS_GPIO && !xbus_i.rd && !xbus_i.wr) |=> (oe_o && out_o == !$past(inv_i)))
		else $error("strobe pin left its idle level");

	a_gpio_drive: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode_i == PCS_GPIO) |=> (oe_o == !$past(latch_i) && !out_o))
		else $error("gpio pin drive wrong for latch");

	a_range_miss: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode_i == PCS_RD && xbus_i.rd && (xbus_i.addr[15:3] != base_i[15:3]))
		|=> (out_o == !$past(inv_i)))
		else $error("read strobe pulsed out of range");

endmodule

// File: rtl/pcs_top.sv
// four-bit port whose pins can act as address-decoded chip selects
// assumes a classic wishbone master on clk_i and the core's move signals
// on the same clock; pins arrive asynchronously
//
// Chosen here: register access over Wishbone.
module pcs_top (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire pcs_pkg::pcs_wb_req_t wb_i,
	output logic                    ack_o,
	output logic [31:0]             dat_o,
	input  wire logic [15:0]        ext_addr_i,
	input  wire logic               ext_rd_n_i,
	input  wire logic               ext_wr_n_i,
	input  wire logic [3:0]         pin_i,
	output logic [3:0]              pin_o,
	output logic [3:0]              pin_oe_o,
	input  wire logic               ext_irq_two_en_i,
	input  wire logic               ext_irq_three_en_i,
	output logic                    ext_irq_two_n_o,
	output logic                    ext_irq_three_n_o
);
	import pcs_pkg::*;

`include "pcs_consts.svh"

	pcs_top_st_t st_q;
	pcs_top_st_t st_d;
	pcs_xbus_t   xbus;
	logic        req;
	logic        wr_en;
	logic [7:0]  wbyte;
	logic [3:0]  hi_sel;
	logic [3:0]  lo_sel;
	logic [3:0]  strobe_mode;
	logic [3:0]  rd_only;
	logic [3:0]  wr_only;
	pcs_mode_t   mode  [`PCS_PINS];
	logic [1:0]  size  [`PCS_PINS];
	logic [3:0]  inv;

	assign xbus.addr = ext_addr_i;
	assign xbus.rd   = ~ext_rd_n_i;
	assign xbus.wr   = ~ext_wr_n_i;

	assign req   = wb_i.cyc & wb_i.stb & (st_q.st == PCS_ST_IDLE);
	assign wr_en = req & wb_i.we & wb_i.sel[0];
	assign wbyte = wb_i.dat[7:0];

	// field of each pin in its control register
	always_comb begin
		logic [7:0] ctrl;
		logic [3:0] fld;
		ctrl = '0;
		fld  = '0;
		for (int i = 0; i < `PCS_PINS; i++) begin
			ctrl = (i < `PCS_PINS_PER_CTRL) ? st_q.ctrl_a : st_q.ctrl_b;
			fld  = ctrl[(i % `PCS_PINS_PER_CTRL) * `PCS_FLD_W +: `PCS_FLD_W];
			mode[i]        = pcs_mode_t'(fld[`PCS_MODE_LSB +: 2]);
			size[i]        = fld[`PCS_SIZE_LSB +: 2];
			strobe_mode[i] = (mode[i] != PCS_GPIO);
			rd_only[i]     = (mode[i] == PCS_RD);
			wr_only[i]     = (mode[i] == PCS_WR);
			inv[i]         = st_q.ext_ctrl[`PCS_INV_LSB + i];
		end
	end

	// which base register the bus address names, if any
	always_comb begin
		hi_sel = '0;
		lo_sel = '0;
		for (int i = 0; i < `PCS_PINS; i++) begin
			hi_sel[i] = (wb_i.adr == 8'(`PCS_OFF_BASE_HI0 + i * `PCS_BASE_STRIDE));
			lo_sel[i] = (wb_i.adr == 8'(`PCS_OFF_BASE_LO0 + i * `PCS_BASE_STRIDE));
		end
	end

	always_comb begin
		st_d = st_q;

		// three-stage pin synchroniser; a level counts once stages two and three agree
		st_d.s1 = pin_i;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		for (int i = 0; i < `PCS_PINS; i++) begin
			if (st_q.s2[i] == st_q.s3[i]) begin
				st_d.pin[i] = st_q.s3[i];
			end
		end

		// external interrupt inputs are active low; a strobe pin still feeds them
		st_d.irq3_n = ext_irq_three_en_i ? st_q.pin[2] : 1'b1;
		st_d.irq2_n = ext_irq_two_en_i ? st_q.pin[3] : 1'b1;

		// bus: ack one cycle after the request is taken, then drop it
		case (st_q.st)
			PCS_ST_IDLE: begin
				if (req) begin
					st_d.st = PCS_ST_ACK;
				end
			end
			PCS_ST_ACK: begin
				st_d.st = PCS_ST_IDLE;
			end
			default: begin
				st_d.st = PCS_ST_IDLE;
			end
		endcase

		if (req) begin
			st_d.rdat = '0;
			if (wb_i.adr == `PCS_OFF_PORT) begin
				// reads return the pin levels, not the latch, as the plain port does
				st_d.rdat[7:0] = {`PCS_HI_ZERO, st_q.pin};
			end else if (wb_i.adr == `PCS_OFF_CTRL_A) begin
				st_d.rdat[7:0] = st_q.ctrl_a;
			end else if (wb_i.adr == `PCS_OFF_CTRL_B) begin
				st_d.rdat[7:0] = st_q.ctrl_b;
			end else if (wb_i.adr == `PCS_OFF_EXT_CTRL) begin
				st_d.rdat[7:0] = st_q.ext_ctrl;
			end else if (|hi_sel) begin
				for (int i = 0; i < `PCS_PINS; i++) begin
					if (hi_sel[i]) begin
						st_d.rdat[7:0] = st_q.base_hi[i];
					end
				end
			end else if (|lo_sel) begin
				for (int i = 0; i < `PCS_PINS; i++) begin
					if (lo_sel[i]) begin
						st_d.rdat[7:0] = st_q.base_lo[i];
					end
				end
			end
		end

		if (wr_en) begin
			if (wb_i.adr == `PCS_OFF_PORT) begin
				// all four bits latch, but a strobe pin ignores its latch bit
				st_d.latch = wbyte[3:0];
			end else if (wb_i.adr == `PCS_OFF_CTRL_A) begin
				st_d.ctrl_a = wbyte;
			end else if (wb_i.adr == `PCS_OFF_CTRL_B) begin
				st_d.ctrl_b = wbyte;
			end else if (wb_i.adr == `PCS_OFF_EXT_CTRL) begin
				st_d.ext_ctrl = wbyte;
			end else if (|hi_sel) begin
				for (int i = 0; i < `PCS_PINS; i++) begin
					if (hi_sel[i]) begin
						st_d.base_hi[i] = wbyte;
					end
				end
			end else if (|lo_sel) begin
				for (int i = 0; i < `PCS_PINS; i++) begin
					if (lo_sel[i]) begin
						st_d.base_lo[i] = wbyte;
					end
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q          <= '0;
			st_q.st       <= PCS_ST_IDLE;
			st_q.ctrl_a   <= `PCS_REG_RST;
			st_q.ctrl_b   <= `PCS_REG_RST;
			st_q.ext_ctrl <= `PCS_REG_RST;
			st_q.base_hi  <= {`PCS_PINS{`PCS_REG_RST}};
			st_q.base_lo  <= {`PCS_PINS{`PCS_REG_RST}};
			st_q.latch    <= `PCS_PORT_RST;
			st_q.pin      <= `PCS_PORT_RST;
			st_q.s1       <= `PCS_PORT_RST;
			st_q.s2       <= `PCS_PORT_RST;
			st_q.s3       <= `PCS_PORT_RST;
			st_q.irq2_n   <= 1'b1;
			st_q.irq3_n   <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign ack_o             = (st_q.st == PCS_ST_ACK);
	assign dat_o             = st_q.rdat;
	assign ext_irq_two_n_o   = st_q.irq2_n;
	assign ext_irq_three_n_o = st_q.irq3_n;

	// one decoder per pin keeps the pins fully independent
	for (genvar g = 0; g < `PCS_PINS; g++) begin : g_pin
		pcs_chan u_chan (
			.clk_i   (clk_i),
			.rst_i   (rst_i),
			.xbus_i  (xbus),
			.base_i  ({st_q.base_hi[g], st_q.base_lo[g]}),
			.mode_i  (mode[g]),
			.size_i  (size[g]),
			.inv_i   (inv[g]),
			.latch_i (st_q.latch[g]),
			.out_o   (pin_o[g]),
			.oe_o    (pin_oe_o[g])
		);
	end

	// the peripheral only looks at data while its select is active, so the
	// one-cycle lag of the registered strobe sits inside the core's move pulse

	a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		(wb_i.cyc && wb_i.stb && !ack_o) |=> ack_o)
		else $error("bus request not acknowledged next cycle");

	a_ack_drop: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");

	a_port_upper: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && wb_i.adr == `PCS_OFF_PORT) |=> (dat_o[31:4] == '0))
		else $error("port read upper bits not zero");

	a_ctrl_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_en && wb_i.adr == `PCS_OFF_CTRL_A) |=> (st_q.ctrl_a == $past(wbyte)))
		else $error("control a write lost");

	a_base_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_en && wb_i.adr == `PCS_OFF_BASE_HI0) |=> (st_q.base_hi[0] == $past(wbyte)))
		else $error("base high write lost");

	a_latch_mask: assert property (@(posedge clk_i) disable iff (rst_i)
		(strobe_mode == 4'h1 && wr_en && wb_i.adr == `PCS_OFF_PORT)
		|=> ##1 (pin_oe_o[0] && pin_oe_o[3:1] == ~$past(st_q.latch[3:1])))
		else $error("port write disturbed strobe pin");

	a_irq_three: assert property (@(posedge clk_i) disable iff (rst_i)
		(ext_irq_three_en_i && !st_q.pin[2]) |=> !ext_irq_three_n_o)
		else $error("pin two low did not reach irq three");

	a_irq_off: assert property (@(posedge clk_i) disable iff (rst_i)
		(!ext_irq_two_en_i) |=> ext_irq_two_n_o)
		else $error("irq two active while disabled");

	a_rw_strobe: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode[3] == PCS_RW && (xbus.rd || xbus.wr)
		&& ext_addr_i == {st_q.base_hi[3], st_q.base_lo[3]})
		|=> (pin_o[3] == $past(inv[3])))
		else $error("read-write strobe missing");

	a_ack_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		!req |=> !ack_o)
		else $error("ack without a request");

	a_dat_upper: assert property (@(posedge clk_i) disable iff (rst_i)
		req |=> (dat_o[31:8] == 24'h000000))
		else $error("read data above bit 7 not zero");

	a_dat_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!req |=> $stable(dat_o))
		else $error("read data moved without a request");

	a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && wb_i.adr != `PCS_OFF_PORT && wb_i.adr != `PCS_OFF_CTRL_A
		&& wb_i.adr != `PCS_OFF_CTRL_B && wb_i.adr != `PCS_OFF_EXT_CTRL
		&& !(|hi_sel) && !(|lo_sel)) |=> (dat_o == 32'h00000000))
		else $error("unmapped read not zero");

	a_port_read: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_i.we && wb_i.adr == `PCS_OFF_PORT)
		|=> (dat_o[3:0] == $past(st_q.pin)))
		else $error("port read not the pin levels");

	a_ctrl_b_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_en && wb_i.adr == `PCS_OFF_CTRL_B) |=> (st_q.ctrl_b == $past(wbyte)))
		else $error("control b write lost");

	a_ext_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_en && wb_i.adr == `PCS_OFF_EXT_CTRL) |=> (st_q.ext_ctrl == $past(wbyte)))
		else $error("extension control write lost");

	a_latch_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_en && wb_i.adr == `PCS_OFF_PORT) |=> (st_q.latch == $past(wbyte[3:0])))
		else $error("port latch write lost");

	a_latch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!wr_en |=> $stable(st_q.latch))
		else $error("port latch moved without a write");

	a_ctrl_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!wr_en |=> ($stable(st_q.ctrl_a) && $stable(st_q.ctrl_b) && $stable(st_q.ext_ctrl)))
		else $error("control moved without a write");

	a_base_lo_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_en && wb_i.adr == `PCS_OFF_BASE_LO0) |=> (st_q.base_lo[0] == $past(wbyte)))
		else $error("base low write lost");

	a_base_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!wr_en |=> ($stable(st_q.base_hi) && $stable(st_q.base_lo)))
		else $error("base moved without a write");

	a_gpio_oe_all: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> ((pin_oe_o & ~$past(strobe_mode))
		== (~$past(st_q.latch) & ~$past(strobe_mode))))
		else $error("gpio pin enable does not follow latch");

	a_gpio_low: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> ((pin_o & ~$past(strobe_mode)) == 4'h0))
		else $error("gpio pin drives high");

	a_strobe_oe: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> ((pin_oe_o & $past(strobe_mode)) == $past(strobe_mode)))
		else $error("strobe pin not driven");

	a_strobe_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		(!xbus.rd && !xbus.wr) |=> (((pin_o ^ ~$past(inv)) & $past(strobe_mode)) == 4'h0))
		else $error("strobe pin off idle without a move");

	a_rd_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(xbus.wr && !xbus.rd) |=> (((pin_o ^ ~$past(inv)) & $past(rd_only)) == 4'h0))
		else $error("read strobe pulsed on a write");

	a_wr_no_read: assert property (@(posedge clk_i) disable iff (rst_i)
		(xbus.rd && !xbus.wr) |=> (((pin_o ^ ~$past(inv)) & $past(wr_only)) == 4'h0))
		else $error("write strobe pulsed on a read");

	a_irq_two: assert property (@(posedge clk_i) disable iff (rst_i)
		(ext_irq_two_en_i && !st_q.pin[3]) |=> !ext_irq_two_n_o)
		else $error("pin three low did not reach irq two");

	a_irq_two_high: assert property (@(posedge clk_i) disable iff (rst_i)
		(ext_irq_two_en_i && st_q.pin[3]) |=> ext_irq_two_n_o)
		else $error("irq two active with pin three high");

	a_irq_three_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!ext_irq_three_en_i |=> ext_irq_three_n_o)
		else $error("irq three active while disabled");

	a_irq_three_high: assert property (@(posedge clk_i) disable iff (rst_i)
		(ext_irq_three_en_i && st_q.pin[2]) |=> ext_irq_three_n_o)
		else $error("irq three active with pin two high");

	a_sync_agree: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> (((st_q.pin ^ $past(st_q.pin)) & ($past(st_q.s2) ^ $past(st_q.s3))) == 4'h0))
		else $error("pin level taken before stages agreed");

endmodule

// File: tb/pcs_periph.sv
// peripheral on strobe pin 0: counts the cycles it is selected
// assumes the bench resolves the pin wire and tells it the active level
module pcs_periph (
	input  wire logic clk_i,
	input  wire logic cs_i,
	input  wire logic act_hi_i,
	output int        sel_cnt_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial sel_cnt_o = 0;
	// only an active select counts; an idle pin is ignored, a released (pulled-up) pin only while the select is active low
	always @(posedge clk_i) begin
		if (cs_i === act_hi_i) sel_cnt_o <= sel_cnt_o + 1;
	end
endmodule

// File: tb/test_port_chip_select_decoder.sv
// bench of the chip-select port: wishbone tasks, random moves, peripheral
// assumes pins pulled up when not driven; irq enables driven by the bench
module test_port_chip_select_decoder;
	timeunit 1ns;
	timeprecision 1ps;
	import pcs_pkg::*;
	logic clk_i = 0, rst_i = 1, ack_o, ext_rd_n = 1, ext_wr_n = 1, inv = 0;
	logic irq2_n, irq3_n;
	pcs_wb_req_t wb_req = '0;
	logic [1:0]  irq_en = 2'b11;
	logic [31:0] dat_o, r;
	logic [15:0] ext_addr = '0, base;
	logic [3:0]  pin_o, pin_oe, pin_w;
	integer seed = 32'h2d5fc653;
	int mismatches = 0, checks = 0, cnt, c0, hits, sz, k;
	logic [15:0] a;
	assign pin_w = (pin_oe & pin_o) | ~pin_oe;
	pcs_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_req), .ack_o(ack_o),
		.dat_o(dat_o), .ext_addr_i(ext_addr), .ext_rd_n_i(ext_rd_n),
		.ext_wr_n_i(ext_wr_n), .pin_i(pin_w), .pin_o(pin_o), .pin_oe_o(pin_oe),
		.ext_irq_two_en_i(irq_en[1]), .ext_irq_three_en_i(irq_en[0]),
		.ext_irq_two_n_o(irq2_n), .ext_irq_three_n_o(irq3_n));
	pcs_periph i_periph (.clk_i(clk_i), .cs_i(pin_w[0]), .act_hi_i(inv), .sel_cnt_o(cnt));
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// one classic cycle; held until ack is sampled high
	task automatic wb_xfer(input logic we, input logic [7:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: ad, dat: d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		r = dat_o;
		if (n >= 50) chk(0, 1, "no ack");
		wb_req <= '0;
	endtask
	function automatic logic exp_pin(input logic [15:0] ad, input int m, input int kk);
		logic hit;
		hit = (((ad ^ base) >> sz) == 0) && ((m == 1 && kk == 1) || (m == 2 && kk == 2)
			|| (m == 3 && kk != 0));
		hits += hit;
		return hit ? inv : ~inv;
	endfunction
	// kk: 0 idle, 1 read, 2 write; each move stays on the bus two cycles
	task automatic move(input logic [15:0] ad, input int kk, input int m);
		logic e;
		@(posedge clk_i);
		ext_addr <= ad;
		ext_rd_n <= (kk != 1);
		ext_wr_n <= (kk != 2);
		@(posedge clk_i);
		#1;
		e = exp_pin(ad, m, kk);
		chk(pin_o[0], e, "strobe level");
	endtask
	initial begin
		#100000;
		chk(0, 1, "watchdog");
		give_verdict();
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		wb_xfer(0, 8'hd8, 0);
		chk(r, 32'h0f, "port reset");
		wb_xfer(0, 8'ha0, 0);
		chk(r, 0, "ctrl reset");
		wb_xfer(0, 8'hfc, 0);
		chk(r, 0, "unmapped");
		$display("test reset done");
		wb_xfer(1, 8'hd8, 32'hf5);
		repeat (6) @(posedge clk_i);
		#1;
		chk(pin_oe, 4'ha, "gpio oe");
		chk(pin_o, 4'h0, "gpio out");
		chk(irq2_n, 1'b0, "irq two");
		chk(irq3_n, 1'b1, "irq three");
		wb_xfer(0, 8'hd8, 0);
		chk(r, 32'h05, "port read");
		wb_xfer(1, 8'hd8, 32'hf0);
		repeat (6) @(posedge clk_i);
		#1;
		chk(irq3_n, 1'b0, "irq three low");
		@(posedge clk_i);
		irq_en <= 2'b00;
		repeat (2) @(posedge clk_i);
		#1;
		chk({irq2_n, irq3_n}, 2'b11, "irq disabled");
		@(posedge clk_i);
		irq_en <= 2'b11;
		$display("test gpio done");
		base = 16'($random(seed));
		wb_xfer(1, 8'h80, base[15:8]);
		wb_xfer(1, 8'h88, ~base[15:8]);
		wb_xfer(0, 8'h80, 0);
		chk(r, base[15:8], "base high");
		wb_xfer(0, 8'h88, 0);
		chk(r, 8'(~base[15:8]), "base high pin1");
		$display("test base done");
		for (int m = 1; m < 4; m++) begin
			for (int v = 0; v < 2; v++) begin
				sz = $random(seed) & 3;
				base = 16'($random(seed));
				wb_xfer(1, 8'h80, base[15:8]);
				wb_xfer(1, 8'h84, base[7:0]);
				wb_xfer(1, 8'ha0, 32'(m * 4 + sz));
				wb_xfer(1, 8'ha8, 32'(v * 16));
				inv = v[0];
				wb_xfer(1, 8'hd8, 32'h01);
				@(posedge clk_i);
				#1;
				chk(pin_oe, 4'hf, "port with strobe oe");
				chk(pin_o, {3'b000, ~inv}, "port with strobe out");
				c0 = cnt;
				hits = 0;
				move(base, 2, m);
				move(base, 1, m);
				repeat (30) begin
					a = base + 16'($random(seed) % 8);
					k = ($random(seed) & 32'h7fff) % 3;
					move(a, k, m);
				end
				move(base, 0, m);
				@(posedge clk_i);
				chk(cnt - c0, hits * 2, "selected cycles");
			end
		end
		$display("test strobe done");
		wb_xfer(1, 8'h98, 32'h12);
		wb_xfer(1, 8'h9c, 32'h34);
		wb_xfer(1, 8'ha4, 32'hc0);
		wb_xfer(1, 8'ha8, 32'h80);
		wb_xfer(0, 8'ha4, 0);
		chk(r, 32'hc0, "ctrl b");
		@(posedge clk_i);
		ext_addr <= 16'h1234;
		ext_wr_n <= 1'b0;
		@(posedge clk_i);
		#1;
		chk(pin_o[3], 1'b1, "pin three strobe");
		@(posedge clk_i);
		ext_wr_n <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		chk(pin_o[3], 1'b0, "pin three idle");
		$display("test pins done");
		give_verdict();
	end
endmodule
